// ==== rtl/adc_regs_pkg.sv ====
package adc_regs_pkg;

	// ----------------------------------------------------------------
	// register map, byte offsets within the board window
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_BOARD_IDENTITY = 12'h000;
	localparam logic [11:0] OFS_CONTROL_AND_STATUS = 12'h002;
	localparam logic [11:0] OFS_SOFT_RESET_COMMAND = 12'h00C;
	localparam logic [11:0] OFS_SOFT_TRIGGER_COMMAND = 12'h00E;
	localparam logic [11:0] OFS_TIMER_CONTROL = 12'h026;
	localparam logic [11:0] OFS_BUFFER_FIRST = 12'h080;
	localparam logic [11:0] OFS_BUFFER_LAST = 12'h87E;
	localparam logic [11:0] OFS_SCRATCH_FIRST = 12'h880;
	localparam logic [11:0] OFS_SCRATCH_LAST = 12'hFFE;
	// plain read/write words: configuration, rate, interrupt control,
	// interrupt vector, auto gain, timer low, timer high, counter
	localparam int CFG_COUNT = 8;
	localparam logic [11:0] CFG_OFS [0:7] = '{12'h004, 12'h006, 12'h008,
		12'h00A, 12'h010, 12'h020, 12'h022, 12'h024};
	localparam int CFG_IDX_INT_CONTROL = 2;
	localparam int CFG_IDX_INT_VECTOR = 3;

	// ----------------------------------------------------------------
	// control_and_status field positions and reset values
	// ----------------------------------------------------------------
	localparam int CSR_INDICATOR_DISABLE = 15;
	localparam int CSR_TWOS_COMPLEMENT = 14;
	localparam int CSR_TRIG_HI = 13;
	localparam int CSR_TRIG_LO = 12;
	localparam int CSR_TIMER_CHAIN = 11;
	localparam int CSR_READY_AT_HALF = 10;
	localparam int CSR_CALIBRATION_DONE = 7;
	localparam int CSR_DATA_READY = 6;
	localparam int CSR_ARMED = 5;
	localparam int CSR_TRIGGERED = 4;
	localparam logic [15:0] CSR_CTRL_MASK = 16'hFC00;
	localparam logic [15:0] CSR_CTRL_RESET = 16'h0000;
	localparam logic [15:0] CFG_RESET = 16'h0000;

	// trigger sources and channel count codes
	localparam logic [1:0] TRIG_SOFTWARE = 2'h0;
	localparam logic [1:0] TRIG_EXTERNAL = 2'h1;
	localparam logic [1:0] TRIG_TIMER = 2'h2;
	localparam logic [1:0] CHANNELS_64 = 2'h0;
	localparam logic [1:0] CHANNELS_32 = 2'h1;
	localparam logic [1:0] CHANNELS_16 = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic [11:0] addr;
		logic [1:0] byte_en;
		logic [15:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic indicator_on;
		logic twos_complement_select;
		logic [1:0] trigger_source;
		logic timer_chain_enable;
		logic ready_at_half;
	} csr_ctrl_t;

	typedef enum logic [2:0] {
		CAL_IDLE = 3'h1,
		CAL_START = 3'h2,
		CAL_BUSY = 3'h4
	} cal_state_t;

endpackage

// ==== rtl/adc_board_control_status_regs.sv ====
`timescale 1ns/100ps
module adc_board_control_status_regs #(
	parameter logic [1:0] CHANNEL_CODE = adc_regs_pkg::CHANNELS_64,
	// identity value is arbitrary
	parameter logic [7:0] IDENTITY_CODE = 8'h5A,
	parameter int BUF_WORDS = 1024,
	parameter int SCRATCH_WORDS = 960
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire adc_regs_pkg::bus_req_t i_bus,
	output logic o_bus_ack,
	output logic [15:0] o_bus_rdata,
	input wire logic i_cal_done,
	input wire logic i_scan_done,
	input wire logic i_scan_armed,
	input wire logic i_trigger_valid,
	input wire logic i_sample_we,
	input wire logic [9:0] i_sample_addr,
	input wire logic [15:0] i_sample_data,
	output adc_regs_pkg::csr_ctrl_t o_ctrl,
	output logic [15:0] o_cfg [0:7],
	output logic o_cal_start,
	output logic o_soft_reset,
	output logic o_soft_trigger,
	output logic o_timer_control_we,
	output logic [15:0] o_timer_control_data
);

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [11:0] a,
		input logic [11:0] ofs);
		hit = (a[11:1] == ofs[11:1]);
	endfunction
	function automatic logic in_span(input logic [11:0] a,
		input logic [11:0] lo, input logic [11:0] hi);
		in_span = (a >= lo) && (a <= hi);
	endfunction
	// lanes: byte_en[1] is the upper byte, byte_en[0] the lower
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] data, input logic [1:0] be);
		merge = {be[1] ? data[15:8] : old[15:8],
			be[0] ? data[7:0] : old[7:0]};
	endfunction
	logic wr;
	logic rd;
	logic soft_rst_hit;
	logic mem_read;
	logic [10:0] word_addr;
	logic [9:0] buf_idx;
	logic [9:0] scr_idx;
	logic in_buf;
	logic in_scr;
	// ----------------------------------------------------------------
	// access decode
	// ----------------------------------------------------------------
	assign wr = i_bus.valid && i_bus.write;
	assign rd = i_bus.valid && !i_bus.write;
	assign word_addr = i_bus.addr[11:1];
	assign in_buf = in_span(i_bus.addr, adc_regs_pkg::OFS_BUFFER_FIRST,
		adc_regs_pkg::OFS_BUFFER_LAST);
	assign in_scr = in_span(i_bus.addr, adc_regs_pkg::OFS_SCRATCH_FIRST,
		adc_regs_pkg::OFS_SCRATCH_LAST);
	assign buf_idx = 10'(word_addr - adc_regs_pkg::OFS_BUFFER_FIRST[11:1]);
	assign scr_idx = 10'(word_addr - adc_regs_pkg::OFS_SCRATCH_FIRST[11:1]);
	assign mem_read = rd && (in_buf || in_scr);
	// data written to the command word is ignored
	assign soft_rst_hit = wr &&
		hit(i_bus.addr, adc_regs_pkg::OFS_SOFT_RESET_COMMAND);
	// ----------------------------------------------------------------
	// calibration sequencer
	// ----------------------------------------------------------------
	adc_regs_pkg::cal_state_t cal_state_reg;
	adc_regs_pkg::cal_state_t cal_state_next;
	// a soft reset restarts calibration from any state
	always_comb begin
		cal_state_next = cal_state_reg;
		case (cal_state_reg)
			adc_regs_pkg::CAL_IDLE: cal_state_next = adc_regs_pkg::CAL_IDLE;
			adc_regs_pkg::CAL_START: cal_state_next = adc_regs_pkg::CAL_BUSY;
			adc_regs_pkg::CAL_BUSY: begin
				if (i_cal_done) begin
					cal_state_next = adc_regs_pkg::CAL_IDLE;
				end
			end
			default: cal_state_next = adc_regs_pkg::CAL_START;
		endcase
		if (soft_rst_hit) begin
			cal_state_next = adc_regs_pkg::CAL_START;
		end
	end
	// system reset lands in the start state so calibration runs at once
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cal_state_reg <= adc_regs_pkg::CAL_START;
		end else begin
			cal_state_reg <= cal_state_next;
		end
	end
	logic calibration_done;
	assign calibration_done = (cal_state_reg == adc_regs_pkg::CAL_IDLE);
	assign o_cal_start = (cal_state_reg == adc_regs_pkg::CAL_START);

	// ----------------------------------------------------------------
	// control_and_status control field
	// ----------------------------------------------------------------
	logic [15:0] csr_ctrl_reg;
	// only bits 15:10 are stored, the rest of a write is dropped
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			csr_ctrl_reg <= adc_regs_pkg::CSR_CTRL_RESET;
		end else if (soft_rst_hit) begin
			csr_ctrl_reg <= adc_regs_pkg::CSR_CTRL_RESET;
		end else if (wr &&
			hit(i_bus.addr, adc_regs_pkg::OFS_CONTROL_AND_STATUS)) begin
			csr_ctrl_reg <= merge(csr_ctrl_reg, i_bus.wdata, i_bus.byte_en) &
				adc_regs_pkg::CSR_CTRL_MASK;
		end
	end
	// control outputs straight from the stored field
	assign o_ctrl.indicator_on =
		!csr_ctrl_reg[adc_regs_pkg::CSR_INDICATOR_DISABLE];
	assign o_ctrl.twos_complement_select =
		csr_ctrl_reg[adc_regs_pkg::CSR_TWOS_COMPLEMENT];
	assign o_ctrl.trigger_source = csr_ctrl_reg[adc_regs_pkg::CSR_TRIG_HI:
		adc_regs_pkg::CSR_TRIG_LO];
	assign o_ctrl.timer_chain_enable =
		csr_ctrl_reg[adc_regs_pkg::CSR_TIMER_CHAIN];
	assign o_ctrl.ready_at_half =
		csr_ctrl_reg[adc_regs_pkg::CSR_READY_AT_HALF];

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	logic data_ready_reg;
	logic armed_reg;
	logic triggered_reg;
	// scan completion beats a clearing read in the same cycle
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			data_ready_reg <= 1'b0;
		end else if (i_scan_done) begin
			data_ready_reg <= 1'b1;
		end else if (mem_read) begin
			data_ready_reg <= 1'b0;
		end
	end
	// re-arming wins over a trigger in the same cycle
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			armed_reg <= 1'b0;
		end else if (soft_rst_hit) begin
			armed_reg <= 1'b0;
		end else if (i_scan_armed) begin
			armed_reg <= 1'b1;
		end else if (i_trigger_valid) begin
			armed_reg <= 1'b0;
		end
	end
	// a new trigger wins over the completion of the previous scan
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			triggered_reg <= 1'b0;
		end else if (soft_rst_hit) begin
			triggered_reg <= 1'b0;
		end else if (i_trigger_valid) begin
			triggered_reg <= 1'b1;
		end else if (i_scan_done) begin
			triggered_reg <= 1'b0;
		end
	end
	logic [15:0] csr_word;
	assign csr_word = {csr_ctrl_reg[15:10], 2'b00, calibration_done,
		data_ready_reg, armed_reg, triggered_reg, 4'h0};

	// ----------------------------------------------------------------
	// plain read/write words
	// ----------------------------------------------------------------
	logic [15:0] cfg_reg [0:7];
	generate
		for (genvar g = 0; g < adc_regs_pkg::CFG_COUNT; g++) begin : g_cfg
			localparam logic keep = (g == adc_regs_pkg::CFG_IDX_INT_CONTROL) ||
				(g == adc_regs_pkg::CFG_IDX_INT_VECTOR);
			// interrupt words survive a soft reset
			always_ff @(posedge i_ref_clk or posedge i_rst) begin
				if (i_rst) begin
					cfg_reg[g] <= adc_regs_pkg::CFG_RESET;
				end else if (soft_rst_hit && !keep) begin
					cfg_reg[g] <= adc_regs_pkg::CFG_RESET;
				end else if (wr && hit(i_bus.addr, adc_regs_pkg::CFG_OFS[g])) begin
					cfg_reg[g] <= merge(cfg_reg[g], i_bus.wdata,
						i_bus.byte_en);
				end
			end
			assign o_cfg[g] = cfg_reg[g];
		end
	endgenerate

	// ----------------------------------------------------------------
	// write-only commands, one-cycle registered pulses
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_soft_reset <= 1'b0;
			o_soft_trigger <= 1'b0;
			o_timer_control_we <= 1'b0;
			o_timer_control_data <= 16'h0000;
		end else begin
			o_soft_reset <= soft_rst_hit;
			o_soft_trigger <= wr &&
				hit(i_bus.addr, adc_regs_pkg::OFS_SOFT_TRIGGER_COMMAND);
			o_timer_control_we <= wr &&
				hit(i_bus.addr, adc_regs_pkg::OFS_TIMER_CONTROL);
			if (wr && hit(i_bus.addr, adc_regs_pkg::OFS_TIMER_CONTROL)) begin
				o_timer_control_data <= merge(o_timer_control_data,
					i_bus.wdata, i_bus.byte_en);
			end
		end
	end

	// ----------------------------------------------------------------
	// sample buffer and scratch memory
	// ----------------------------------------------------------------
	logic [15:0] buf_mem [0:BUF_WORDS-1];
	logic [15:0] scr_mem [0:SCRATCH_WORDS-1];
	// converter port written last: it wins on the same word only,
	// a bus write to another word in that cycle still lands
	always_ff @(posedge i_ref_clk) begin
		if (wr && in_buf) begin
			if (i_bus.byte_en[1]) begin
				buf_mem[buf_idx][15:8] <= i_bus.wdata[15:8];
			end
			if (i_bus.byte_en[0]) begin
				buf_mem[buf_idx][7:0] <= i_bus.wdata[7:0];
			end
		end
		if (i_sample_we) begin
			buf_mem[i_sample_addr] <= i_sample_data;
		end
		if (wr && in_scr) begin
			if (i_bus.byte_en[1]) begin
				scr_mem[scr_idx][15:8] <= i_bus.wdata[15:8];
			end
			if (i_bus.byte_en[0]) begin
				scr_mem[scr_idx][7:0] <= i_bus.wdata[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// read mux and acknowledge, one cycle after the access
	// ----------------------------------------------------------------
	logic [15:0] reg_rdata;
	// byte reads get the whole word, the master picks its lane
	always_comb begin
		reg_rdata = 16'h0000; // unmapped and write-only words read zero
		if (hit(i_bus.addr, adc_regs_pkg::OFS_BOARD_IDENTITY)) begin
			reg_rdata = {IDENTITY_CODE, 6'h00, CHANNEL_CODE};
		end else if (hit(i_bus.addr, adc_regs_pkg::OFS_CONTROL_AND_STATUS)) begin
			reg_rdata = csr_word;
		end
		for (int k = 0; k < adc_regs_pkg::CFG_COUNT; k++) begin
			if (hit(i_bus.addr, adc_regs_pkg::CFG_OFS[k])) begin
				reg_rdata = cfg_reg[k];
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_bus_ack <= 1'b0;
			o_bus_rdata <= 16'h0000;
		end else begin
			o_bus_ack <= i_bus.valid;
			if (rd && in_buf) begin
				o_bus_rdata <= buf_mem[buf_idx];
			end else if (rd && in_scr) begin
				o_bus_rdata <= scr_mem[scr_idx];
			end else if (rd) begin
				o_bus_rdata <= reg_rdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_soft_reset_write;
		soft_rst_hit;
	endsequence
	sequence s_calibration_restart;
		o_cal_start && !calibration_done ##1 !calibration_done;
	endsequence

	AST_ID_CONST: assert property (
		rd && hit(i_bus.addr, adc_regs_pkg::OFS_BOARD_IDENTITY) |=>
		o_bus_ack && o_bus_rdata == {IDENTITY_CODE, 6'h00, CHANNEL_CODE})
		else $error("identity word wrong");
	AST_ACK_NEXT: assert property (
		i_bus.valid |=> o_bus_ack ##1 !o_bus_ack || $past(i_bus.valid))
		else $error("access not acknowledged next cycle");
	AST_INDICATOR: assert property (
		wr && i_bus.byte_en[1] &&
		hit(i_bus.addr, adc_regs_pkg::OFS_CONTROL_AND_STATUS) |=>
		o_ctrl.indicator_on == !$past(i_bus.wdata[15]))
		else $error("indicator does not follow bit 15");
	AST_TRIG_SRC: assert property (
		wr && i_bus.byte_en[1] &&
		hit(i_bus.addr, adc_regs_pkg::OFS_CONTROL_AND_STATUS) |=>
		o_ctrl.trigger_source == $past(i_bus.wdata[13:12]))
		else $error("trigger source not stored");
	AST_SOFT_RESET: assert property (
		s_soft_reset_write |=> o_soft_reset && o_cal_start &&
		csr_ctrl_reg == adc_regs_pkg::CSR_CTRL_RESET && !armed_reg &&
		!triggered_reg)
		else $error("soft reset did not restore defaults");
	AST_CAL_CLEAR: assert property (
		s_soft_reset_write |=> s_calibration_restart)
		else $error("calibration done not cleared");
	AST_DATA_READY: assert property (
		mem_read && !i_scan_done |=> !data_ready_reg ##1
		(data_ready_reg == $past(i_scan_done)))
		else $error("data ready clear or set wrong");
	// a soft reset in the same cycle clears both flags instead
	AST_ARMED_CLR: assert property (
		i_trigger_valid && !i_scan_armed && !soft_rst_hit |=>
		!armed_reg && triggered_reg)
		else $error("trigger did not move armed to triggered");
	AST_TRIGGERED_CLR: assert property (
		i_scan_done && !i_trigger_valid |=> !triggered_reg && data_ready_reg)
		else $error("completion did not clear triggered");
	// bit 7 is compared with the state at the cycle of the read
	AST_RESERVED_ZERO: assert property (
		rd && hit(i_bus.addr, adc_regs_pkg::OFS_CONTROL_AND_STATUS) |=>
		o_bus_rdata[9:8] == 2'b00 && o_bus_rdata[3:0] == 4'h0 &&
		o_bus_rdata[7] == $past(calibration_done))
		else $error("status word reserved bits not zero");
	AST_LOW_LANE_ONLY: assert property (
		wr && i_bus.byte_en == 2'b01 &&
		hit(i_bus.addr, adc_regs_pkg::OFS_CONTROL_AND_STATUS) |=>
		$stable(o_ctrl))
		else $error("low byte write touched control field");

endmodule

// ==== sim/host_bus_master.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------
// host side of the register bus: one-cycle strobe, answer next edge
// ----------------------------------------------------------------
module host_bus_master (
	input wire logic i_ref_clk,
	input wire logic i_bus_ack,
	input wire logic [15:0] i_bus_rdata,
	output adc_regs_pkg::bus_req_t o_bus
);

	// idle bus at time zero
	initial begin
		o_bus = '0;
	end

	// one transfer; idle adds slow-host gaps before the strobe
	task automatic access(input logic w, input logic [11:0] a,
		input logic [1:0] be, input logic [15:0] d, input int idle,
		output logic [15:0] q, output logic ok);
		repeat (idle) @(posedge i_ref_clk);
		@(posedge i_ref_clk);
		#1;
		o_bus = '{valid: 1'b1, write: w, addr: a, byte_en: be, wdata: d};
		@(posedge i_ref_clk);
		#1;
		ok = i_bus_ack;
		q = i_bus_rdata;
		// released lines show inverted garbage, not the last value
		o_bus = '{valid: 1'b0, write: ~w, addr: ~a, byte_en: ~be,
			wdata: ~d};
	endtask

endmodule

// ==== sim/adc_board_control_status_regs_tb_top.sv ====
`timescale 1ns/100ps
module adc_board_control_status_regs_tb_top;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam logic [11:0] id_a = adc_regs_pkg::OFS_BOARD_IDENTITY;
	localparam logic [11:0] ctl_a = adc_regs_pkg::OFS_CONTROL_AND_STATUS;
	// identity code 5a is arbitrary, channel code 00 (64 channels)
	localparam logic [15:0] ID_EXP = 16'h5A00;
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	adc_regs_pkg::bus_req_t bus;
	logic ack;
	logic [15:0] rdata;
	logic cal_done = 1'b0;
	logic scan_done = 1'b0;
	logic scan_armed = 1'b0;
	logic trig_valid = 1'b0;
	logic sample_we = 1'b0;
	logic [9:0] sample_addr = 10'h000;
	logic [15:0] sample_data = 16'h0000;
	adc_regs_pkg::csr_ctrl_t ctrl;
	logic [15:0] cfg [0:7];
	logic cal_start;
	logic soft_reset;
	logic soft_trigger;
	logic tc_we;
	logic [15:0] tc_data;
	int fails = 0;
	int n_checks = 0;
	logic [15:0] q;
	logic ok;

	// 50 MHz
	always #10 i_ref_clk = ~i_ref_clk;

	adc_board_control_status_regs i_adc_board_control_status_regs (
		.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_bus(bus),
		.o_bus_ack(ack), .o_bus_rdata(rdata), .i_cal_done(cal_done),
		.i_scan_done(scan_done), .i_scan_armed(scan_armed),
		.i_trigger_valid(trig_valid), .i_sample_we(sample_we),
		.i_sample_addr(sample_addr), .i_sample_data(sample_data),
		.o_ctrl(ctrl), .o_cfg(cfg), .o_cal_start(cal_start),
		.o_soft_reset(soft_reset), .o_soft_trigger(soft_trigger),
		.o_timer_control_we(tc_we), .o_timer_control_data(tc_data)
	);

	host_bus_master i_host_bus_master (
		.i_ref_clk(i_ref_clk), .i_bus_ack(ack), .i_bus_rdata(rdata),
		.o_bus(bus)
	);

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// every transfer must be answered on the next edge
	task automatic wr(input logic [11:0] a, input logic [1:0] be,
		input logic [15:0] d);
		i_host_bus_master.access(1'b1, a, be, d, 0, q, ok);
		chk({15'h0, ok}, 16'h0001);
	endtask

	task automatic rd(input logic [11:0] a, input logic [15:0] exp);
		i_host_bus_master.access(1'b0, a, 2'b11, 16'h0000, 1, q, ok);
		chk({15'h0, ok}, 16'h0001);
		chk(q, exp);
	endtask

	// one-cycle pulse on {cal_done, scan_done, scan_armed, trig_valid}
	task automatic stat(input logic [3:0] p);
		@(posedge i_ref_clk);
		#1;
		{cal_done, scan_done, scan_armed, trig_valid} = p;
		@(posedge i_ref_clk);
		#1;
		{cal_done, scan_done, scan_armed, trig_valid} = 4'h0;
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge i_ref_clk);
		#1;
		i_rst = 1'b0;
		chk({10'h000, ctrl}, 16'h0020);
		chk({15'h0, cal_start}, 16'h0001);
		rd(id_a, ID_EXP);
		wr(id_a, 2'b11, 16'hFFFF);
		rd(id_a, ID_EXP);
		rd(ctl_a, 16'h0000);
		stat(4'h8);
		rd(ctl_a, 16'h0080);
		$display("test reset done");
		// reserved and status bits must not take writes
		wr(ctl_a, 2'b11, 16'hFFFF);
		rd(ctl_a, 16'hFC80);
		chk({10'h000, ctrl}, 16'h001F);
		wr(ctl_a, 2'b01, 16'h0000);
		rd(ctl_a, 16'hFC80);
		wr(ctl_a, 2'b10, 16'h00FF);
		rd(ctl_a, 16'h0080);
		// one control bit at a time, indicator sense inverted
		for (int b = 10; b < 16; b++) begin
			wr(ctl_a, 2'b11, 16'h0001 << b);
			rd(ctl_a, (16'h0001 << b) | 16'h0080);
			chk({10'h000, ctrl}, ((16'h0001 << b) >> 10) ^ 16'h0020);
		end
		for (int i = 0; i < 4; i++) begin
			wr(ctl_a, 2'b11, 16'(i) << 12);
			chk({14'h0, ctrl.trigger_source}, 16'(i));
		end
		$display("test control done");
		for (int i = 0; i < 8; i++) begin
			wr(adc_regs_pkg::CFG_OFS[i], 2'b11, 16'hA500 | 16'(i));
		end
		for (int i = 0; i < 8; i++) begin
			rd(adc_regs_pkg::CFG_OFS[i], 16'hA500 | 16'(i));
			chk(cfg[i], 16'hA500 | 16'(i));
		end
		rd(12'h012, 16'h0000);
		rd(12'h028, 16'h0000);
		rd(adc_regs_pkg::OFS_TIMER_CONTROL, 16'h0000);
		wr(adc_regs_pkg::OFS_SOFT_TRIGGER_COMMAND, 2'b11, 16'h1234);
		chk({15'h0, soft_trigger}, 16'h0001);
		wr(adc_regs_pkg::OFS_TIMER_CONTROL, 2'b11, 16'hBEEF);
		chk({15'h0, tc_we}, 16'h0001);
		chk(tc_data, 16'hBEEF);
		$display("test decode done");
		// status flags with trigger source 11 still selected
		stat(4'h2);
		rd(ctl_a, 16'h30A0);
		stat(4'h1);
		rd(ctl_a, 16'h3090);
		stat(4'h4);
		rd(ctl_a, 16'h30C0);
		wr(adc_regs_pkg::OFS_SCRATCH_FIRST, 2'b11, 16'hC3C3);
		wr(adc_regs_pkg::OFS_SCRATCH_LAST, 2'b11, 16'h3C3C);
		rd(ctl_a, 16'h30C0);
		rd(adc_regs_pkg::OFS_SCRATCH_LAST, 16'h3C3C);
		rd(ctl_a, 16'h3080);
		rd(adc_regs_pkg::OFS_SCRATCH_FIRST, 16'hC3C3);
		stat(4'h4);
		@(posedge i_ref_clk);
		#1;
		{sample_we, sample_addr, sample_data} = {1'b1, 10'h005, 16'h6C6C};
		@(posedge i_ref_clk);
		#1;
		sample_we = 1'b0;
		rd(12'h08A, 16'h6C6C);
		rd(ctl_a, 16'h3080);
		wr(adc_regs_pkg::OFS_BUFFER_LAST, 2'b11, 16'h0F0F);
		rd(adc_regs_pkg::OFS_BUFFER_LAST, 16'h0F0F);
		// converter and bus write different buffer words in one cycle
		fork
			wr(12'h08C, 2'b11, 16'h1111);
			begin
				@(posedge i_ref_clk);
				#1;
				{sample_we, sample_addr, sample_data} =
					{1'b1, 10'h007, 16'h2222};
				@(posedge i_ref_clk);
				#1;
				sample_we = 1'b0;
			end
		join
		rd(12'h08C, 16'h1111);
		rd(12'h08E, 16'h2222);
		$display("test status done");
		// soft reset keeps interrupt words and data-ready
		stat(4'h6);
		wr(adc_regs_pkg::OFS_SOFT_RESET_COMMAND, 2'b11, 16'h5555);
		chk({14'h0, soft_reset, cal_start}, 16'h0003);
		chk({10'h000, ctrl}, 16'h0020);
		for (int i = 0; i < 8; i++) begin
			chk(cfg[i], (i == 2 || i == 3) ? 16'hA500 | 16'(i) : 16'h0000);
		end
		rd(ctl_a, 16'h0040);
		stat(4'h8);
		rd(ctl_a, 16'h00C0);
		// second system reset in mid-run
		@(posedge i_ref_clk);
		#1;
		i_rst = 1'b1;
		repeat (2) @(posedge i_ref_clk);
		#1;
		i_rst = 1'b0;
		for (int i = 0; i < 8; i++) begin
			chk(cfg[i], 16'h0000);
		end
		rd(ctl_a, 16'h0000);
		$display("test resets done");
		results();
	end

	// whole run is well under a thousand cycles
	initial begin
		#100_000;
		fails++;
		$display("BAD t=%0t run did not finish", $time);
		results();
	end

endmodule
